// File: rtl/pfgh_pkg.sv
// package: register map, field layout, function codes and carrier types for the port f/g/h pin mux
// Functional notes
// - port f pin 1 field bits 6..4 of select 1: 000 gpio, 001 lcd 27.
// - port f pin 0 field bits 2..0 of select 1: 000 gpio, 001 lcd 26.
// - port f pin 3 field bits 6..4 of select 2: 000 gpio, 001 lcd 29.
// - port f pin 2 field bits 2..0 of select 2: 000 gpio, 001 lcd 28.
// - port f pin 5 field bits 6..4 of select 3: 000 gpio, 001 lcd 31.
// - port f pin 4 field bits 2..0 of select 3: 000 gpio, 001 lcd 30.
// - port f pin 7: gpio, flex timer clock, analog 5, lcd 33.
// - port f pin 6: gpio, modulo timer clock, analog 4, lcd 32.
// - port g pin 1: gpio, spi1 miso, analog 7, lcd 35.
// - port g pin 0: gpio, spi1 mosi, analog 6, lcd 34.
// - port g pin 3: gpio, spi1 slave select, analog 9, lcd 37.
// - port g pin 2: gpio, spi1 clock, analog 8, lcd 36.
// - port g pin 5: gpio, comparator 2 out, uart3 transmit, analog 11, lcd 39.
// - port g pin 4: gpio, comparator 1 out, uart3 receive, analog 10, lcd 38.
// - port g pin 7: gpio, comparator input 4, analog 13, pulse counter 1, lcd 41.
// - port g pin 6: gpio, comparator input 3, analog 12, pulse counter 0, lcd 40.
// - port h pin 1: gpio, real-time clock out, analog 15, lcd 43.
// - port h pin 0: gpio, comparator input 5, analog 14, pulse counter 2, lcd 42.
// - bits 7 and 3 read zero; all select bits reset to zero, pins gpio.
package pfgh_pkg;

   localparam int PFGH_PINS = 18;
   localparam int PFGH_NREGS = 9;
   localparam int PFGH_ADDR_W = 12;
   localparam int PIN_PG_BASE = 8;
   localparam int PIN_PH_BASE = 16;
   localparam int ADC_FIRST_PIN = 6;

   // register byte offsets, one aligned word each
   localparam logic [11:0] OFF_PORT_F_FUNCTION_SEL_1 = 12'h000;
   localparam logic [11:0] OFF_PORT_F_FUNCTION_SEL_2 = 12'h004;
   localparam logic [11:0] OFF_PORT_F_FUNCTION_SEL_3 = 12'h008;
   localparam logic [11:0] OFF_PORT_F_FUNCTION_SEL_4 = 12'h00C;
   localparam logic [11:0] OFF_PORT_G_FUNCTION_SEL_1 = 12'h010;
   localparam logic [11:0] OFF_PORT_G_FUNCTION_SEL_2 = 12'h014;
   localparam logic [11:0] OFF_PORT_G_FUNCTION_SEL_3 = 12'h018;
   localparam logic [11:0] OFF_PORT_G_FUNCTION_SEL_4 = 12'h01C;
   localparam logic [11:0] OFF_PORT_H_FUNCTION_SEL_1 = 12'h020;
   localparam logic [11:0] OFF_PIN_LEVEL = 12'h024;
   localparam logic [8:0][11:0] REG_OFF = {
      OFF_PORT_H_FUNCTION_SEL_1, OFF_PORT_G_FUNCTION_SEL_4, OFF_PORT_G_FUNCTION_SEL_3,
      OFF_PORT_G_FUNCTION_SEL_2, OFF_PORT_G_FUNCTION_SEL_1, OFF_PORT_F_FUNCTION_SEL_4,
      OFF_PORT_F_FUNCTION_SEL_3, OFF_PORT_F_FUNCTION_SEL_2, OFF_PORT_F_FUNCTION_SEL_1};

   // field layout: even pin in the low field, odd pin in the high field
   localparam int FIELD_LO_LSB = 0;
   localparam int FIELD_HI_LSB = 4;
   localparam int FIELD_W = 3;
   localparam logic [7:0] REG_WMASK = 8'h77;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic UART_RX_IDLE = 1'b1;

   // spi1 signal slots in the spi carrier
   localparam int SPI_MOSI = 0;
   localparam int SPI_MISO = 1;
   localparam int SPI_SCLK = 2;
   localparam int SPI_SS = 3;

   // function codes
   localparam logic [2:0] C_GPIO = 3'h0;
   localparam logic [2:0] C_PF_LCD = 3'h1;
   localparam logic [2:0] C_PF6_MOD_CLK = 3'h1;
   localparam logic [2:0] C_PF6_AD = 3'h2;
   localparam logic [2:0] C_PF6_LCD = 3'h3;
   localparam logic [2:0] C_PF7_FLEX_CLK = 3'h1;
   localparam logic [2:0] C_PF7_AD = 3'h2;
   localparam logic [2:0] C_PF7_LCD = 3'h3;
   localparam logic [2:0] C_PG_SPI = 3'h1;
   localparam logic [2:0] C_PG_SPI_AD = 3'h2;
   localparam logic [2:0] C_PG_SPI_LCD = 3'h3;
   localparam logic [2:0] C_PG4_CMP1_OUT = 3'h1;
   localparam logic [2:0] C_PG4_UART_RX = 3'h2;
   localparam logic [2:0] C_PG4_AD = 3'h3;
   localparam logic [2:0] C_PG4_LCD = 3'h4;
   localparam logic [2:0] C_PG5_CMP2_OUT = 3'h1;
   localparam logic [2:0] C_PG5_UART_TX = 3'h2;
   localparam logic [2:0] C_PG5_AD = 3'h3;
   localparam logic [2:0] C_PG5_LCD = 3'h4;
   localparam logic [2:0] C_PCNT_CMP_IN = 3'h1;
   localparam logic [2:0] C_PCNT_AD = 3'h2;
   localparam logic [2:0] C_PCNT_PULSE = 3'h3;
   localparam logic [2:0] C_PCNT_LCD = 3'h4;
   localparam logic [2:0] C_PH1_RTC_OUT = 3'h1;
   localparam logic [2:0] C_PH1_AD = 3'h2;
   localparam logic [2:0] C_PH1_LCD = 3'h3;

   // pad or gpio drive: one bit per pin
   typedef struct packed {
      logic [PFGH_PINS-1:0] out;
      logic [PFGH_PINS-1:0] oe;
   } pfgh_pin_drv_type;

   // spi1 drive, slots as above
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } pfgh_spi_drv_type;

   // whole state of the mux
   typedef struct packed {
      logic [PFGH_NREGS-1:0][7:0] fsel;
      logic [PFGH_PINS-1:0] sync1;
      logic [PFGH_PINS-1:0] sync2;
      logic [PFGH_PINS-1:0] gpio_in;
      pfgh_pin_drv_type pad;
      logic [31:0] rdata;
      logic [PFGH_PINS-1:0] lcd_pin;
      logic [PFGH_PINS-1:0] adc_pin;
      logic [PFGH_PINS-1:0] cmp_pin;
      logic [PFGH_PINS-1:0] analog;
      logic [3:0] spi_in;
      logic uart_rx;
      logic mod_clk;
      logic flex_clk;
      logic [2:0] pulse;
   } pfgh_state_type;

endpackage

// File: rtl/pfgh_pin_mux.sv
// module: apb-controlled function select mux for port f, port g and port h pins 0..1
`timescale 1ns/1ns
module pfgh_pin_mux
   import pfgh_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PFGH_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pfgh_pin_drv_type gpio_drv,
   output logic [PFGH_PINS-1:0] gpio_in,
   output pfgh_pin_drv_type pad_drv,
   input wire logic [PFGH_PINS-1:0] pad_in,
   output logic [PFGH_PINS-1:0] pad_analog_en,
   output logic [PFGH_PINS-1:0] lcd_line_en,
   output logic [11:0] adc_chan_en,
   output logic comparator_input_three,
   output logic comparator_input_four,
   output logic comparator_input_five,
   input wire pfgh_spi_drv_type spi1_drv,
   output logic [3:0] spi1_in,
   input wire logic uart_three_transmit,
   output logic uart_three_receive,
   input wire logic comparator_one_output,
   input wire logic comparator_two_output,
   input wire logic realtime_clock_output,
   output logic modulo_timer_clock_in,
   output logic flex_timer_ext_clock_in,
   output logic pulse_counter_input_zero,
   output logic pulse_counter_input_one,
   output logic pulse_counter_input_two
);

   pfgh_state_type s_q;
   pfgh_state_type s_d;
   logic hit_reg;
   logic hit_any;
   logic [3:0] hit_idx;

   // address decode; only word-aligned offsets of the map answer
   always_comb begin
      hit_reg = 1'b0;
      hit_idx = 4'h0;
      for (int k = 0; k < PFGH_NREGS; k++) begin
         if (paddr == REG_OFF[k]) begin
            hit_reg = 1'b1;
            hit_idx = 4'(k);
         end
      end
      hit_any = hit_reg | (paddr == OFF_PIN_LEVEL);
   end

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   // next-state logic
   always_comb begin
      logic [PFGH_PINS-1:0][2:0] sel;
      sel = '0;
      s_d = s_q;
      for (int i = 0; i < PFGH_PINS; i++) begin
         if (i % 2 == 1) begin
            sel[i] = s_q.fsel[i / 2][FIELD_HI_LSB +: FIELD_W];
         end else begin
            sel[i] = s_q.fsel[i / 2][FIELD_LO_LSB +: FIELD_W];
         end
      end

      // two-stage pad input synchroniser; stage one feeds stage two only
      s_d.sync1 = pad_in;
      s_d.sync2 = s_q.sync1;
      s_d.gpio_in = s_q.sync2;

      // defaults: pad belongs to gpio, every peripheral input sits idle
      s_d.pad = gpio_drv;
      s_d.lcd_pin = '0;
      s_d.adc_pin = '0;
      s_d.cmp_pin = '0;
      s_d.spi_in = '0;
      s_d.uart_rx = UART_RX_IDLE;
      s_d.mod_clk = 1'b0;
      s_d.flex_clk = 1'b0;
      s_d.pulse = '0;

      // port f pins 0..5 carry only lcd lines 26..31
      for (int i = 0; i < ADC_FIRST_PIN; i++) begin
         s_d.lcd_pin[i] = (sel[i] == C_PF_LCD);
      end

      // port f pin 6; the timer clock is input-only, so gpio must let go of the pad
      case (sel[6])
         C_PF6_MOD_CLK: begin
            s_d.pad.oe[6] = 1'b0;
            s_d.pad.out[6] = 1'b0;
            s_d.mod_clk = s_q.sync2[6];
         end
         C_PF6_AD: s_d.adc_pin[6] = 1'b1;
         C_PF6_LCD: s_d.lcd_pin[6] = 1'b1;
         default: ; // gpio or reserved
      endcase

      // port f pin 7; same input-only release as pin 6
      case (sel[7])
         C_PF7_FLEX_CLK: begin
            s_d.pad.oe[7] = 1'b0;
            s_d.pad.out[7] = 1'b0;
            s_d.flex_clk = s_q.sync2[7];
         end
         C_PF7_AD: s_d.adc_pin[7] = 1'b1;
         C_PF7_LCD: s_d.lcd_pin[7] = 1'b1;
         default: ;
      endcase

      // port g pins 0..3: spi1 mosi, miso, sclk, ss in slot order
      for (int j = 0; j < 4; j++) begin
         case (sel[PIN_PG_BASE + j])
            C_PG_SPI: begin
               s_d.pad.out[PIN_PG_BASE + j] = spi1_drv.out[j];
               s_d.pad.oe[PIN_PG_BASE + j] = spi1_drv.oe[j];
               s_d.spi_in[j] = s_q.sync2[PIN_PG_BASE + j];
            end
            C_PG_SPI_AD: s_d.adc_pin[PIN_PG_BASE + j] = 1'b1;
            C_PG_SPI_LCD: s_d.lcd_pin[PIN_PG_BASE + j] = 1'b1;
            default: ;
         endcase
      end

      // port g pin 4
      case (sel[PIN_PG_BASE + 4])
         C_PG4_CMP1_OUT: begin
            s_d.pad.out[PIN_PG_BASE + 4] = comparator_one_output;
            s_d.pad.oe[PIN_PG_BASE + 4] = 1'b1;
         end
         C_PG4_UART_RX: begin
            s_d.pad.oe[PIN_PG_BASE + 4] = 1'b0;
            s_d.pad.out[PIN_PG_BASE + 4] = 1'b0;
            s_d.uart_rx = s_q.sync2[PIN_PG_BASE + 4];
         end
         C_PG4_AD: s_d.adc_pin[PIN_PG_BASE + 4] = 1'b1;
         C_PG4_LCD: s_d.lcd_pin[PIN_PG_BASE + 4] = 1'b1;
         default: ;
      endcase

      // port g pin 5
      case (sel[PIN_PG_BASE + 5])
         C_PG5_CMP2_OUT: begin
            s_d.pad.out[PIN_PG_BASE + 5] = comparator_two_output;
            s_d.pad.oe[PIN_PG_BASE + 5] = 1'b1;
         end
         C_PG5_UART_TX: begin
            s_d.pad.out[PIN_PG_BASE + 5] = uart_three_transmit;
            s_d.pad.oe[PIN_PG_BASE + 5] = 1'b1;
         end
         C_PG5_AD: s_d.adc_pin[PIN_PG_BASE + 5] = 1'b1;
         C_PG5_LCD: s_d.lcd_pin[PIN_PG_BASE + 5] = 1'b1;
         default: ;
      endcase

      // port g pins 6, 7 and port h pin 0 share one layout
      for (int j = 0; j < 3; j++) begin
         case (sel[PIN_PG_BASE + 6 + j])
            C_PCNT_CMP_IN: s_d.cmp_pin[PIN_PG_BASE + 6 + j] = 1'b1;
            C_PCNT_AD: s_d.adc_pin[PIN_PG_BASE + 6 + j] = 1'b1;
            C_PCNT_PULSE: begin
               s_d.pad.oe[PIN_PG_BASE + 6 + j] = 1'b0;
               s_d.pad.out[PIN_PG_BASE + 6 + j] = 1'b0;
               s_d.pulse[j] = s_q.sync2[PIN_PG_BASE + 6 + j];
            end
            C_PCNT_LCD: s_d.lcd_pin[PIN_PG_BASE + 6 + j] = 1'b1;
            default: ;
         endcase
      end

      // port h pin 1
      case (sel[PIN_PH_BASE + 1])
         C_PH1_RTC_OUT: begin
            s_d.pad.out[PIN_PH_BASE + 1] = realtime_clock_output;
            s_d.pad.oe[PIN_PH_BASE + 1] = 1'b1;
         end
         C_PH1_AD: s_d.adc_pin[PIN_PH_BASE + 1] = 1'b1;
         C_PH1_LCD: s_d.lcd_pin[PIN_PH_BASE + 1] = 1'b1;
         default: ;
      endcase

      // an analog owner takes the pad: digital driver off so it cannot fight the lcd or adc
      s_d.analog = s_d.lcd_pin | s_d.adc_pin | s_d.cmp_pin;
      for (int i = 0; i < PFGH_PINS; i++) begin
         if (s_d.analog[i]) begin
            s_d.pad.out[i] = 1'b0;
            s_d.pad.oe[i] = 1'b0;
         end
      end

      // register write at the access edge; reserved bits 7 and 3 stay zero
      if (psel && penable && pwrite && hit_reg && pstrb[0]) begin
         s_d.fsel[hit_idx] = pwdata[7:0] & REG_WMASK;
      end

      // read data captured in the setup cycle so it comes from a flip-flop
      if (psel && !penable) begin
         s_d.rdata = '0;
         if (hit_reg) begin
            s_d.rdata = {24'h000000, s_q.fsel[hit_idx]};
         end else if (paddr == OFF_PIN_LEVEL) begin
            s_d.rdata = {14'h0000, s_q.sync2};
         end
      end
   end

   // state register; every pin comes up as gpio
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.fsel <= {PFGH_NREGS{REG_RESET}};
         s_q.uart_rx <= UART_RX_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign prdata = s_q.rdata;
   assign gpio_in = s_q.gpio_in;
   assign pad_drv = s_q.pad;
   assign pad_analog_en = s_q.analog;
   assign lcd_line_en = s_q.lcd_pin;
   assign adc_chan_en = s_q.adc_pin[PFGH_PINS-1:ADC_FIRST_PIN];
   assign comparator_input_three = s_q.cmp_pin[PIN_PG_BASE + 6];
   assign comparator_input_four = s_q.cmp_pin[PIN_PG_BASE + 7];
   assign comparator_input_five = s_q.cmp_pin[PIN_PH_BASE];
   assign spi1_in = s_q.spi_in;
   assign uart_three_receive = s_q.uart_rx;
   assign modulo_timer_clock_in = s_q.mod_clk;
   assign flex_timer_ext_clock_in = s_q.flex_clk;
   assign pulse_counter_input_zero = s_q.pulse[0];
   assign pulse_counter_input_one = s_q.pulse[1];
   assign pulse_counter_input_two = s_q.pulse[2];

endmodule

// File: tb/pfgh_pin_mux_asserts.sv
// checker: port-level assertions for the port f/g/h pin mux
`timescale 1ns/1ns
module pfgh_pin_mux_chk
   import pfgh_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PFGH_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire pfgh_pin_drv_type pad_drv,
   input wire logic [PFGH_PINS-1:0] pad_analog_en,
   input wire logic [PFGH_PINS-1:0] lcd_line_en,
   input wire logic [11:0] adc_chan_en,
   input wire logic comparator_input_three,
   input wire logic pulse_counter_input_zero
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // low byte of a select register is written at this edge
   wire logic wr_lo = psel && penable && pwrite && pstrb[0];
   property p_rd_zero; psel && penable && !pwrite && paddr <= 12'h020 |-> prdata[31:8] == 24'h0 && !prdata[7] && !prdata[3]; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("unused select bits read nonzero");
   property p_excl; (lcd_line_en[17:6] & adc_chan_en) == 12'h0; endproperty
   a_excl: assert property (p_excl) else $error("pin has lcd and analog together");
   property p_lcd_own; (lcd_line_en & ~pad_analog_en) == 18'h0; endproperty
   a_lcd_own: assert property (p_lcd_own) else $error("lcd pin not released by pad");
   // a pad handed to analog use must never be driven, else it fights the segment or input
   property p_quiet; (pad_analog_en & pad_drv.oe) == 18'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("analog pin driven");
   property p_cmp; !(comparator_input_three && pulse_counter_input_zero); endproperty
   a_cmp: assert property (p_cmp) else $error("two functions on one pin");
   property p_wr_lcd; wr_lo && paddr == 12'h000 && pwdata[2:0] == 3'h1 |-> ##2 lcd_line_en[0] && pad_analog_en[0]; endproperty
   a_wr_lcd: assert property (p_wr_lcd) else $error("lcd line not selected");
   property p_rsvd; wr_lo && paddr == 12'h018 && pwdata[6:4] > 3'h4 |-> ##2 !pad_analog_en[13] && !lcd_line_en[13]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved code took the pin");
   property p_adc; wr_lo && paddr == 12'h010 && pwdata[2:0] == 3'h2 |-> ##2 adc_chan_en[2] && !lcd_line_en[8]; endproperty
   a_adc: assert property (p_adc) else $error("analog input not selected");
   c_rsvd: cover property (wr_lo && paddr == 12'h018);
   c_cmp: cover property (comparator_input_three);
   c_err: cover property (pslverr);
endmodule

bind pfgh_pin_mux pfgh_pin_mux_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .prdata, .pslverr, .pad_drv, .pad_analog_en, .lcd_line_en, .adc_chan_en,
   .comparator_input_three, .pulse_counter_input_zero);

// File: tb/pfgh_periph_model.sv
// model: gpio and peripheral drivers on the far side of the pin mux
`timescale 1ns/1ns
module pfgh_periph_model
   import pfgh_pkg::*;
(
   output pfgh_pin_drv_type gpio_drv,
   output pfgh_spi_drv_type spi1_drv,
   output logic uart_three_transmit,
   output logic comparator_one_output,
   output logic comparator_two_output,
   output logic realtime_clock_output
);
   // gpio drives every pin high, so a peripheral low level stands out on the pad
   assign gpio_drv = '{out: 18'h3FFFF, oe: 18'h3FFFF};
   // spi drives slots 0 and 2 low; slots 1 and 3 are inputs here
   assign spi1_drv = '{out: 4'h0, oe: 4'h5};
   // outputs rest low, opposite to gpio; limitation: a swap between them goes unseen
   assign uart_three_transmit = 1'b0;
   assign comparator_one_output = 1'b0;
   assign comparator_two_output = 1'b0;
   assign realtime_clock_output = 1'b0;
endmodule

// File: tb/tb.sv
// testbench: register access and pin function selection of the port f/g/h pin mux
`timescale 1ns/1ns
module tb;
   import pfgh_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv, uart_three_transmit, uart_three_receive;
   logic comparator_one_output, comparator_two_output, realtime_clock_output, modulo_timer_clock_in;
   logic flex_timer_ext_clock_in, pulse_counter_input_zero, pulse_counter_input_one, pulse_counter_input_two;
   logic comparator_input_three, comparator_input_four, comparator_input_five;
   logic [PFGH_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0] pstrb, spi1_in;
   logic [PFGH_PINS-1:0] gpio_in, pad_in, pad_analog_en, lcd_line_en;
   logic [11:0] adc_chan_en;
   pfgh_pin_drv_type gpio_drv, pad_drv;
   pfgh_spi_drv_type spi1_drv;
   int error_cnt, n_compared;

   pfgh_pin_mux DUT (.*);
   pfgh_periph_model u_model (.*);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task final_report;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, 24'h0, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'h1);
   endtask

   task rd(input logic [11:0] a);
      apb(1'b0, a, 8'h00, 4'h0);
   endtask

   // select code c on pin p, compare peripheral view, then return the pin to gpio
   task sel(input int p, input logic [2:0] c, input logic [15:0] o, input logic [17:0] l, input logic [11:0] a);
      logic [15:0] ob;
      wr(REG_OFF[p / 2], {5'h0, c} << (4 * (p % 2)));
      repeat (3) @(posedge pclk);
      ob = {modulo_timer_clock_in, flex_timer_ext_clock_in, pulse_counter_input_zero, pulse_counter_input_one,
         pulse_counter_input_two, comparator_input_three, comparator_input_four, comparator_input_five,
         uart_three_receive, spi1_in, pad_drv.out[p] & pad_drv.oe[p], pad_drv.oe[p], pad_analog_en[p]};
      chk(ob, o);
      chk(lcd_line_en, l);
      chk(adc_chan_en, a);
      wr(REG_OFF[p / 2], 8'h00);
   endtask

   // watchdog: the sequence needs about 600 cycles
   initial begin
      #200000;
      error_cnt++;
      final_report;
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      pad_in = 18'h3EFFF;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(pad_drv.out, 32'h3FFFF);
      chk(pad_drv.oe, 32'h3FFFF);
      for (int i = 0; i < PFGH_NREGS; i++) begin
         rd(REG_OFF[i]);
         chk(rdv, 32'h0);
         wr(REG_OFF[i], 8'hFF);
         rd(REG_OFF[i]);
         chk(rdv, 32'h77);
         wr(REG_OFF[i], 8'h00);
      end
      // masked strobe, unmapped place and the pad level word
      apb(1'b1, REG_OFF[0], 8'h11, 4'h0);
      rd(REG_OFF[0]);
      chk(rdv, 32'h0);
      apb(1'b1, 12'h040, 8'hFF, 4'h1);
      chk(erv, 32'h1);
      rd(12'h040);
      chk(rdv, 32'h0);
      chk(erv, 32'h1);
      rd(OFF_PIN_LEVEL);
      chk(rdv, 32'h3EFFF);
      chk(erv, 32'h0);
      chk(gpio_in, 32'h3EFFF);
      for (int i = 0; i < 18; i++)
         sel(i, (i < 6) ? 3'h1 : ((i < 12 || i == 17) ? 3'h3 : 3'h4), 16'h0081, 18'h1 << i, 12'h0);
      for (int i = 6; i < 18; i++)
         sel(i, (i == 12 || i == 13) ? 3'h3 : 3'h2, 16'h0081, 18'h0, 12'h1 << (i - 6));
      sel(6, 3'h1, 16'h8080, 18'h0, 12'h0);
      sel(7, 3'h1, 16'h4080, 18'h0, 12'h0);
      sel(14, 3'h3, 16'h2080, 18'h0, 12'h0);
      sel(15, 3'h3, 16'h1080, 18'h0, 12'h0);
      sel(16, 3'h3, 16'h0880, 18'h0, 12'h0);
      sel(14, 3'h1, 16'h0481, 18'h0, 12'h0);
      sel(15, 3'h1, 16'h0281, 18'h0, 12'h0);
      sel(16, 3'h1, 16'h0181, 18'h0, 12'h0);
      sel(12, 3'h2, 16'h0000, 18'h0, 12'h0);
      sel(13, 3'h2, 16'h0082, 18'h0, 12'h0);
      sel(12, 3'h1, 16'h0082, 18'h0, 12'h0);
      sel(17, 3'h1, 16'h0082, 18'h0, 12'h0);
      sel(8, 3'h1, 16'h008A, 18'h0, 12'h0);
      sel(9, 3'h1, 16'h0090, 18'h0, 12'h0);
      sel(10, 3'h1, 16'h00A2, 18'h0, 12'h0);
      sel(11, 3'h1, 16'h00C0, 18'h0, 12'h0);
      sel(0, 3'h2, 16'h0086, 18'h0, 12'h0);
      sel(13, 3'h5, 16'h0086, 18'h0, 12'h0);
      sel(7, 3'h7, 16'h0086, 18'h0, 12'h0);
      // all pads low: peripheral inputs must follow the pad, not a stuck level
      pad_in <= 18'h00000;
      repeat (4) @(posedge pclk);
      chk(gpio_in, 32'h0);
      sel(6, 3'h1, 16'h0080, 18'h0, 12'h0);
      sel(8, 3'h1, 16'h0082, 18'h0, 12'h0);
      sel(14, 3'h3, 16'h0080, 18'h0, 12'h0);
      // a second reset in mid-run clears a live selection
      wr(REG_OFF[0], 8'h11);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(REG_OFF[0]);
      chk(rdv, 32'h0);
      chk(lcd_line_en, 32'h0);
      final_report;
   end
endmodule
